//--- design/ars_cfg.svh
// Constants for the converter readout sequencer: offsets, fields, timing.
// Assumes inclusion by the design through its bare name.
`ifndef ARS_CFG_SVH
`define ARS_CFG_SVH
// ----------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------
`define ARS_CTRL_OFF      12'h000
`define ARS_STATUS_OFF    12'h004
`define ARS_TIMING_OFF    12'h008
`define ARS_RESULT_OFF    12'h00C
`define ARS_PINCFG_OFF    12'h010
`define ARS_PINOUT_OFF    12'h014
`define ARS_PININ_OFF     12'h018
`define ARS_CHRES_OFF     12'h040
`define ARS_CHRES_END     12'h06C
// ----------------------------------------------------------------------
// Control fields
// ----------------------------------------------------------------------
`define ARS_CTRL_EN       0
`define ARS_CTRL_MODE_LO  1
`define ARS_CTRL_CONT     3
`define ARS_CTRL_START    4
`define ARS_CTRL_CH_LO    8
`define ARS_CTRL_PORTBUF  16
// ----------------------------------------------------------------------
// Timing and sizes
// ----------------------------------------------------------------------
`define ARS_CONV_CYCLES   4'hC
`define ARS_IRQ_CYCLES    2'h2
`define ARS_AUTO_LAST     5'h0A
`define ARS_EN_RESET      16'h0010
`define ARS_SAMP_RESET    16'h0008
`define ARS_RESP_OKAY     2'h0
`define ARS_RESP_SLVERR   2'h2
`define ARS_GLITCH_CYCLES 3'h3
`endif

//--- design/ars_pkg.sv
// Types shared by the converter readout sequencer.
// Assumes ars_cfg.svh is on the include path.
package ars_pkg;
    // Readout modes
    typedef enum logic [1:0] {
        ARS_MODE_SINGLE,
        ARS_MODE_ROBIN,
        ARS_MODE_ONCE
    } ars_mode_e;
    // Sequencer states
    typedef enum logic [2:0] {
        ARS_IDLE,
        ARS_ENWAIT,
        ARS_SAMPLE,
        ARS_CONVERT,
        ARS_IRQ
    } ars_state_e;
    // Pin drive styles
    typedef enum logic [1:0] {
        ARS_DRV_FULL,
        ARS_DRV_WEAK,
        ARS_DRV_ODRAIN,
        ARS_DRV_INPUT
    } ars_drive_e;
    // Converter analog handshake
    typedef struct packed {
        logic [4:0] channel;
        logic sample;
        logic convert;
    } ars_afe_s;
endpackage

//--- design/ars_sequencer.sv
// Converter readout sequencer with AXI4-Lite registers and pin buffers.
// Assumes a converter core that returns a 10-bit result on request and
// pins that arrive asynchronously to aclk.
`include "ars_cfg.svh"

module ars_sequencer #(
    parameter int NPINS = 9,
    parameter int RES_W = 10,
    parameter int CNT_W = 16
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output ars_pkg::ars_afe_s afe,
    input wire logic [RES_W-1:0] afe_result,
    output logic done_irq,
    output logic [NPINS-1:0] pin_o,
    output logic [NPINS-1:0] pin_oe,
    output logic [NPINS-1:0] pin_weak,
    output logic [NPINS-1:0] pin_analog,
    input wire logic [NPINS-1:0] pin_i,
    output logic port_node_input_buffer,
    input wire logic port_node_i
);
    initial begin
        if (RES_W != 10 || NPINS < 1 || NPINS > 16 || CNT_W != 16) begin
            $error("ars_sequencer: unsupported parameters");
        end
    end

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic enable;
        ars_pkg::ars_mode_e mode;
        logic cont;
        logic [4:0] sel_ch;
        logic port_buf;
        logic [CNT_W-1:0] en_time;
        logic [CNT_W-1:0] samp_time;
        logic [CNT_W-1:0] samp_cap;
        ars_pkg::ars_state_e st;
        logic [CNT_W-1:0] cnt;
        logic [4:0] ch;
        logic armed;
        logic warm;
        logic last;
        logic [RES_W-1:0] single_res;
        logic [10:0][RES_W-1:0] ch_res;
        logic busy_done;
        logic [NPINS-1:0][1:0] drv;
        logic [NPINS-1:0] up_en;
        logic [NPINS-1:0] dn_en;
        logic [NPINS-1:0] s1;
        logic [NPINS-1:0] s2;
        logic [NPINS-1:0][2:0] gl;
        logic [NPINS-1:0] din;
        logic p1;
        logic p2;
        logic aw_got;
        logic w_got;
        logic [11:0] awaddr;
        logic [31:0] wdata;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } ars_state_s;

    ars_state_s s_reg, s_next;

    // Word index of a channel result address
    function automatic logic [4:0] res_index(input logic [11:0] a);
        logic [11:0] d;
        d = a - `ARS_CHRES_OFF;
        return d[6:2];
    endfunction

    // Address falls in the per-channel result window
    function automatic logic is_res(input logic [11:0] a);
        return a >= `ARS_CHRES_OFF && a <= `ARS_CHRES_END && a[1:0] == 2'h0;
    endfunction

    logic wr_fire;
    logic start_pulse;
    logic [31:0] rd_word;
    logic rd_ok;

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        s_next = s_reg;
        start_pulse = 1'b0;
        rd_word = 32'h0000_0000;
        rd_ok = 1'b1;
        wr_fire = 1'b0;

        // Write address and data taken in either order
        if (s_axi_awvalid && !s_reg.aw_got && !s_reg.bvalid) begin
            s_next.aw_got = 1'b1;
            s_next.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !s_reg.w_got && !s_reg.bvalid) begin
            s_next.w_got = 1'b1;
            s_next.wdata = s_axi_wdata;
        end
        if (s_reg.aw_got && s_reg.w_got) begin
            wr_fire = 1'b1;
            s_next.aw_got = 1'b0;
            s_next.w_got = 1'b0;
            s_next.bvalid = 1'b1;
            s_next.bresp = `ARS_RESP_OKAY;
            if (s_reg.awaddr == `ARS_CTRL_OFF) begin
                s_next.enable = s_reg.wdata[`ARS_CTRL_EN];
                s_next.mode = ars_pkg::ars_mode_e'(
                    s_reg.wdata[`ARS_CTRL_MODE_LO +: 2]);
                s_next.cont = s_reg.wdata[`ARS_CTRL_CONT];
                s_next.sel_ch = s_reg.wdata[`ARS_CTRL_CH_LO +: 5];
                s_next.port_buf = s_reg.wdata[`ARS_CTRL_PORTBUF];
                start_pulse = s_reg.wdata[`ARS_CTRL_START];
            end else if (s_reg.awaddr == `ARS_TIMING_OFF) begin
                s_next.en_time = s_reg.wdata[15:0];
                s_next.samp_time = s_reg.wdata[31:16];
            end else if (s_reg.awaddr == `ARS_PINCFG_OFF) begin
                for (int i = 0; i < NPINS; i++) begin
                    s_next.drv[i] = s_reg.wdata[2*i +: 2];
                end
            end else if (s_reg.awaddr == `ARS_PINOUT_OFF) begin
                s_next.up_en = s_reg.wdata[NPINS-1:0];
                s_next.dn_en = s_reg.wdata[16 +: NPINS];
            end else begin
                s_next.bresp = `ARS_RESP_SLVERR;
            end
        end
        if (s_reg.bvalid && s_axi_bready) begin
            s_next.bvalid = 1'b0;
        end

        // Read decode; result reads never touch the sequencer
        if (s_axi_araddr == `ARS_CTRL_OFF) begin
            rd_word[`ARS_CTRL_EN] = s_reg.enable;
            rd_word[`ARS_CTRL_MODE_LO +: 2] = s_reg.mode;
            rd_word[`ARS_CTRL_CONT] = s_reg.cont;
            rd_word[`ARS_CTRL_CH_LO +: 5] = s_reg.sel_ch;
            rd_word[`ARS_CTRL_PORTBUF] = s_reg.port_buf;
        end else if (s_axi_araddr == `ARS_STATUS_OFF) begin
            rd_word[2:0] = s_reg.st;
            rd_word[8 +: 5] = s_reg.ch;
            rd_word[16] = s_reg.busy_done;
        end else if (s_axi_araddr == `ARS_TIMING_OFF) begin
            rd_word = {s_reg.samp_time, s_reg.en_time};
        end else if (s_axi_araddr == `ARS_RESULT_OFF) begin
            rd_word[RES_W-1:0] = s_reg.single_res;
        end else if (s_axi_araddr == `ARS_PINCFG_OFF) begin
            for (int i = 0; i < NPINS; i++) begin
                rd_word[2*i +: 2] = s_reg.drv[i];
            end
        end else if (s_axi_araddr == `ARS_PINOUT_OFF) begin
            rd_word[NPINS-1:0] = s_reg.up_en;
            rd_word[16 +: NPINS] = s_reg.dn_en;
        end else if (s_axi_araddr == `ARS_PININ_OFF) begin
            rd_word[NPINS-1:0] = s_reg.din;
            rd_word[16] = s_reg.p2 & s_reg.port_buf;
        end else if (is_res(s_axi_araddr)) begin
            rd_word[RES_W-1:0] = s_reg.ch_res[res_index(s_axi_araddr)];
        end else begin
            rd_ok = 1'b0;
        end
        if (s_axi_arvalid && !s_reg.rvalid) begin
            s_next.rvalid = 1'b1;
            s_next.rdata = rd_word;
            s_next.rresp = rd_ok ? `ARS_RESP_OKAY : `ARS_RESP_SLVERR;
        end else if (s_reg.rvalid && s_axi_rready) begin
            s_next.rvalid = 1'b0;
        end

        // Pin input synchronisers and deglitch filters
        s_next.s1 = pin_i;
        s_next.s2 = s_reg.s1;
        s_next.p1 = port_node_i;
        s_next.p2 = s_reg.p1;
        for (int i = 0; i < NPINS; i++) begin
            if (s_reg.s2[i] == s_reg.din[i]) begin
                s_next.gl[i] = 3'h0;
            end else if (s_reg.gl[i] == `ARS_GLITCH_CYCLES) begin
                s_next.din[i] = s_reg.s2[i];
                s_next.gl[i] = 3'h0;
            end else begin
                s_next.gl[i] = s_reg.gl[i] + 3'h1;
            end
        end

        // Start request arms a single or sweep run
        if (start_pulse) begin
            s_next.armed = 1'b1;
            s_next.busy_done = 1'b0;
        end

        // Sequencer
        if (!s_next.enable) begin
            s_next.st = ars_pkg::ARS_IDLE;
            s_next.warm = 1'b0;
            s_next.armed = 1'b0;
            s_next.cnt = '0;
        end else begin
            case (s_reg.st)
                ars_pkg::ARS_IDLE: begin
                    if (s_reg.armed
                        || s_reg.mode == ars_pkg::ARS_MODE_ROBIN) begin
                        s_next.armed = 1'b0;
                        s_next.ch = (s_reg.mode == ars_pkg::ARS_MODE_SINGLE)
                            ? s_reg.sel_ch : 5'h00;
                        s_next.last = 1'b0;
                        s_next.samp_cap = s_reg.samp_time;
                        s_next.cnt = s_reg.warm ? '0 : s_reg.en_time;
                        s_next.st = s_reg.warm ? ars_pkg::ARS_SAMPLE
                            : ars_pkg::ARS_ENWAIT;
                    end
                end
                ars_pkg::ARS_ENWAIT: begin
                    if (s_reg.cnt <= 1) begin
                        s_next.warm = 1'b1;
                        s_next.cnt = '0;
                        s_next.st = ars_pkg::ARS_SAMPLE;
                    end else begin
                        s_next.cnt = s_reg.cnt - 1'b1;
                    end
                end
                ars_pkg::ARS_SAMPLE: begin
                    if (s_reg.cnt + 1'b1 >= s_reg.samp_cap) begin
                        s_next.cnt = '0;
                        s_next.st = ars_pkg::ARS_CONVERT;
                    end else begin
                        s_next.cnt = s_reg.cnt + 1'b1;
                    end
                end
                ars_pkg::ARS_CONVERT: begin
                    if (s_reg.cnt == CNT_W'(`ARS_CONV_CYCLES - 4'h1)) begin
                        s_next.cnt = '0;
                        if (s_reg.mode == ars_pkg::ARS_MODE_SINGLE) begin
                            s_next.single_res = afe_result;
                            s_next.st = ars_pkg::ARS_IRQ;
                        end else begin
                            s_next.ch_res[s_reg.ch[3:0]] = afe_result;
                            if (s_reg.ch == `ARS_AUTO_LAST) begin
                                s_next.ch = 5'h00;
                                if (s_reg.mode == ars_pkg::ARS_MODE_ONCE) begin
                                    s_next.st = ars_pkg::ARS_IRQ;
                                end else begin
                                    s_next.st = ars_pkg::ARS_SAMPLE;
                                    s_next.samp_cap = s_reg.samp_time;
                                end
                            end else begin
                                s_next.ch = s_reg.ch + 5'h01;
                                s_next.st = ars_pkg::ARS_SAMPLE;
                                s_next.samp_cap = s_reg.samp_time;
                            end
                        end
                    end else begin
                        s_next.cnt = s_reg.cnt + 1'b1;
                    end
                end
                ars_pkg::ARS_IRQ: begin
                    if (s_reg.cnt == CNT_W'(`ARS_IRQ_CYCLES - 2'h1)) begin
                        s_next.cnt = '0;
                        s_next.busy_done = 1'b1;
                        if (s_reg.mode == ars_pkg::ARS_MODE_SINGLE
                            && s_reg.cont) begin
                            s_next.samp_cap = s_reg.samp_time;
                            s_next.st = ars_pkg::ARS_SAMPLE;
                        end else begin
                            s_next.st = ars_pkg::ARS_IDLE;
                        end
                    end else begin
                        s_next.cnt = s_reg.cnt + 1'b1;
                    end
                end
                default: begin
                    s_next.st = ars_pkg::ARS_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_reg <= '0;
            s_reg.en_time <= `ARS_EN_RESET;
            s_reg.samp_time <= `ARS_SAMP_RESET;
            s_reg.st <= ars_pkg::ARS_IDLE;
            s_reg.mode <= ars_pkg::ARS_MODE_SINGLE;
            s_reg.drv <= {NPINS{2'(ars_pkg::ARS_DRV_INPUT)}};
        end else begin
            s_reg <= s_next;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign s_axi_awready = !s_reg.aw_got && !s_reg.bvalid;
    assign s_axi_wready = !s_reg.w_got && !s_reg.bvalid;
    assign s_axi_bvalid = s_reg.bvalid;
    assign s_axi_bresp = s_reg.bresp;
    assign s_axi_arready = !s_reg.rvalid;
    assign s_axi_rvalid = s_reg.rvalid;
    assign s_axi_rdata = s_reg.rdata;
    assign s_axi_rresp = s_reg.rresp;

    // Converter handshake and two-cycle interrupt
    assign afe.channel = s_reg.ch;
    assign afe.sample = s_reg.st == ars_pkg::ARS_SAMPLE;
    assign afe.convert = s_reg.st == ars_pkg::ARS_CONVERT;
    assign done_irq = s_reg.st == ars_pkg::ARS_IRQ;
    assign port_node_input_buffer = s_reg.port_buf;

    // Pin drive: pull-down alone gives open drain
    always_comb begin
        for (int i = 0; i < NPINS; i++) begin
            pin_analog[i] = s_reg.drv[i] == 2'(ars_pkg::ARS_DRV_INPUT);
            pin_weak[i] = s_reg.drv[i] == 2'(ars_pkg::ARS_DRV_WEAK);
            if (s_reg.drv[i] == 2'(ars_pkg::ARS_DRV_ODRAIN)) begin
                pin_o[i] = 1'b0;
                pin_oe[i] = s_reg.dn_en[i];
            end else if (pin_analog[i]) begin
                pin_o[i] = 1'b0;
                pin_oe[i] = 1'b0;
            end else begin
                pin_o[i] = s_reg.up_en[i];
                pin_oe[i] = s_reg.up_en[i] ^ s_reg.dn_en[i];
            end
        end
    end
endmodule

//--- tb/adc_readout_sequencer_test.sv
// Self-checking bench for the readout sequencer.
// Assumes the design package, header and checker are compiled first.
`define CHK(g, e) begin \
    num_checks++; \
    if ((g) !== (e)) begin \
        err_count++; \
        $display("CHECK FAILED %0t got %h exp %h", $time, (g), (e)); \
    end \
end
module adc_readout_sequencer_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk = 1'b0, aresetn = 1'b0;
    logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
    logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata, d;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, done_irq, port_node_input_buffer;
    logic [1:0] s_axi_bresp, s_axi_rresp, rs;
    logic [9:0] afe_result = 10'h000, rv, exp_res [0:31];
    logic [8:0] pin_i = 9'h000, pin_o, pin_oe, pin_weak, pin_analog;
    logic port_node_i = 1'b0, irq_s = 1'b0, irq_q = 1'b0, cont_chk = 1'b0;
    ars_pkg::ars_afe_s afe, mon = '0, mon_q = '0;
    logic [4:0] log_q [$];
    int err_count = 0, num_checks = 0, cyc = 0, irq_n = 0;
    int samp_t = 0, samp_len = 0, conv_t = 0, conv_gap = 0, t0, b, ch;

    ars_sequencer uut (.*);

    // Free-running 100 MHz clock
    always #5 aclk = ~aclk;
    // Mid-cycle capture of converter outputs avoids edge races
    always @(negedge aclk) begin
        mon <= afe;
        irq_s <= done_irq;
    end
    // Conversion log, result stimulus and phase timing
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        mon_q <= mon;
        irq_q <= irq_s;
        if (mon.sample) samp_len <= mon_q.sample ? samp_len + 1 : 1;
        if (mon.sample && !mon_q.sample) samp_t <= cyc;
        if (irq_s && !irq_q) irq_n <= irq_n + 1;
        if (cont_chk && irq_q && !irq_s) `CHK(mon.sample, 1'b1)
        if (mon.convert && !mon_q.convert) begin
            rv = 10'($urandom);
            afe_result <= rv;
            exp_res[mon.channel] = rv;
            conv_gap <= cyc - conv_t;
            conv_t <= cyc;
            log_q.push_back(mon.channel);
        end
    end

    // Verdict and end of run
    task automatic test_done();
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic hang();
        err_count++;
        test_done();
    endtask
    // One register access; a write when wr is set
    task automatic axi(input bit wr, input logic [11:0] a,
            input logic [31:0] v);
        logic ta, tw, done;
        int n;
        n = 0;
        done = 1'b0;
        if (wr) begin
            s_axi_awaddr <= a;
            s_axi_wdata <= v;
            s_axi_awvalid <= 1'b1;
            s_axi_wvalid <= 1'b1;
            s_axi_bready <= 1'b1;
        end else begin
            s_axi_araddr <= a;
            s_axi_arvalid <= 1'b1;
            s_axi_rready <= 1'b1;
        end
        while (!done && n < 100) begin
            @(negedge aclk);
            ta = wr ? s_axi_awready : s_axi_arready;
            tw = s_axi_wready;
            done = wr ? s_axi_bvalid : s_axi_rvalid;
            rs = wr ? s_axi_bresp : s_axi_rresp;
            d = s_axi_rdata;
            @(posedge aclk);
            n++;
            if (ta && wr) s_axi_awvalid <= 1'b0;
            if (ta && !wr) s_axi_arvalid <= 1'b0;
            if (tw && wr) s_axi_wvalid <= 1'b0;
        end
        s_axi_bready <= 1'b0;
        s_axi_rready <= 1'b0;
        if (!done) hang();
        // One idle edge before the next request
        @(posedge aclk);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] v);
        axi(1'b1, a, v);
        `CHK(rs, 2'h0)
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        axi(1'b0, a, 32'h0000_0000);
        `CHK(d, e)
        `CHK(rs, 2'h0)
    endtask
    // Bounded wait on the interrupt or conversion count
    task automatic wait_for(input bit use_log, input int tgt, input int lim);
        int n;
        n = 0;
        while ((use_log ? log_q.size() : irq_n) < tgt) begin
            @(posedge aclk);
            n++;
            if (n > lim) hang();
        end
    endtask

    // Main sequence
    initial begin
        void'($urandom(80));
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        `CHK(pin_analog, 9'h1FF)
        rd(12'h008, 32'h0008_0010);
        axi(1'b0, 12'h100, 32'h0000_0000);
        `CHK(rs, 2'h2)
        axi(1'b1, 12'h104, 32'h0000_0001);
        `CHK(rs, 2'h2)
        // Single conversion of a random channel after the enable wait
        ch = $urandom % 32;
        wr(12'h008, 32'h0003_0028);
        b = irq_n;
        wr(12'h000, 32'h0000_0011 | (ch << 8));
        t0 = cyc;
        wait_for(1'b0, b + 1, 300);
        `CHK((samp_t - t0) inside {[36:46]}, 1'b1)
        `CHK(samp_len, 3)
        repeat (40) @(posedge aclk);
        `CHK(log_q.size(), 1)
        `CHK(log_q[0], 5'(ch))
        rd(12'h00C, {22'h0, exp_res[ch]});
        // Repeated conversion, then disable inside the sampling window
        log_q.delete();
        wr(12'h008, 32'h0014_0002);
        cont_chk = 1'b1;
        b = irq_n;
        wr(12'h000, 32'h0000_1619);
        wait_for(1'b0, b + 3, 400);
        repeat (4) @(posedge aclk);
        cont_chk = 1'b0;
        foreach (log_q[i]) `CHK(log_q[i], 5'h16)
        wr(12'h000, 32'h0000_0000);
        b = log_q.size();
        repeat (60) @(posedge aclk);
        `CHK(log_q.size(), b)
        // One sweep over the automatic channels
        log_q.delete();
        wr(12'h008, 32'h0002_0001);
        b = irq_n;
        wr(12'h000, 32'h0000_0015);
        wait_for(1'b0, b + 1, 600);
        repeat (50) @(posedge aclk);
        `CHK(irq_n, b + 1)
        `CHK(log_q.size(), 11)
        rd(12'h004, 32'h0001_0000);
        for (int i = 0; i < 11; i++) begin
            `CHK(log_q[i], 5'(i))
            rd(12'h040 + 12'(4 * i), {22'h0, exp_res[i]});
        end
        // Continuous sweep, read while running, stopped by reset
        wr(12'h000, 32'h0000_0000);
        log_q.delete();
        b = irq_n;
        wr(12'h000, 32'h0000_0003);
        wait_for(1'b1, 16, 1000);
        rd(12'h040, {22'h0, exp_res[0]});
        `CHK(conv_gap, 14)
        for (int i = 0; i < 16; i++) `CHK(log_q[i], 5'(i % 11))
        `CHK(irq_n, b)
        aresetn <= 1'b0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        // Pin drive styles, pull enables and input paths
        wr(12'h010, 32'h0003_FFE4);
        wr(12'h014, 32'h0004_0003);
        `CHK(pin_oe[2:0], 3'h7)
        `CHK(pin_o[2:0], 3'h3)
        `CHK(pin_weak[1:0], 2'h2)
        `CHK(pin_analog, 9'h1F8)
        rd(12'h014, 32'h0004_0003);
        pin_i <= 9'($urandom);
        port_node_i <= 1'b1;
        wr(12'h000, 32'h0001_0000);
        `CHK(port_node_input_buffer, 1'b1)
        repeat (12) @(posedge aclk);
        axi(1'b0, 12'h018, 32'h0000_0000);
        `CHK(d[8:3], pin_i[8:3])
        `CHK(d[16], 1'b1)
        pin_i <= ~pin_i;
        @(posedge aclk);
        pin_i <= ~pin_i;
        repeat (12) @(posedge aclk);
        axi(1'b0, 12'h018, 32'h0000_0000);
        `CHK(d[8:3], pin_i[8:3])
        wr(12'h000, 32'h0000_0000);
        `CHK(port_node_input_buffer, 1'b0)
        test_done();
    end
endmodule

//--- tb/ars_seq_assertions.sv
// Port-level checks for the readout sequencer.
// Assumes it is bound to ars_sequencer and sees only its ports.
module ars_seq_assertions (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire ars_pkg::ars_afe_s afe,
    input wire logic done_irq
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    // Phase shapes
    sequence conv_run;
        afe.convert[*6] ##1 afe.convert[*6] ##1 !afe.convert;
    endsequence
    sequence irq_run;
        done_irq[*2] ##1 !done_irq;
    endsequence
    // Converter phases and interrupt
    chk_conv_twelve: assert property ($rose(afe.convert) |-> conv_run)
        else $error("conversion length wrong");
    chk_samp_first: assert property (
        $rose(afe.convert) |-> $past(afe.sample))
        else $error("conversion without sampling");
    chk_phase_excl: assert property (!(afe.sample && afe.convert))
        else $error("sample and convert together");
    chk_irq_two: assert property ($rose(done_irq) |-> irq_run)
        else $error("interrupt not two cycles");
    chk_irq_after: assert property (
        $rose(done_irq) |-> $fell(afe.convert))
        else $error("interrupt not at conversion end");
    chk_ch_steady: assert property (afe.convert |-> $stable(afe.channel))
        else $error("channel moved during conversion");
    // Host reads answered one cycle after acceptance, refused while one is pending; read data and write responses held until taken
    chk_read_answer: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    chk_rdata_hold: assert property (
        s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    chk_bresp_hold: assert property (
        s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    chk_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while answer pending");
endmodule

bind ars_sequencer ars_seq_assertions u_chk (.aclk(aclk), .aresetn(aresetn),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .afe(afe), .done_irq(done_irq));
